/* File: tb_top.sv */
// Purpose: Self-checking bench for the thermal and fan monitor
// Assumes: Fan tick cut to 8 cycles
// Notes: Recorder and firmware strobes are counted as they pass
`default_nettype none
module tb_top
  import tfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rev = 1'b0;
  logic aux = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [PWR_W-1:0] pwr = 12'h000;
  logic [TEMP_W-1:0] tmp [3] = '{8'h19, 8'h19, 8'h19};
  logic cyc, stb, we, ack, men, sen, pg, al_n, nwe, fws;
  logic [ADDR_W-1:0] adr;
  logic [1:0] led;
  logic [2:0] nadr, slot;
  logic [RPM_W-1:0] rpm;
  logic [31:0] wd, rdt, nd, fww, rec, fw, q;
  int failures = 0, n_tests = 0, n_rec = 0, n_fw = 0, cyc_n = 0;
  always #4 clk = ~clk;
  tfm_host host_u (.clk_in(clk), .cyc_out(cyc), .stb_out(stb), .we_out(we),
    .adr_out(adr), .dat_out(wd), .ack_in(ack), .dat_in(rdt));
  tfm_monitor #(.FAN_TICK_CYC(TICK)) dut_u (.clk_in(clk), .rstn_in(rstn),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rdt), .wb_ack_out(ack),
    .reverse_airflow_variant_in(rev), .temp_inlet_in(tmp[0]),
    .temp_rect1_in(tmp[1]), .temp_rect2_in(tmp[2]), .output_power_in(pwr),
    .aux_affected_in(aux), .overvoltage_fault_in(flt[0]),
    .overcurrent_fault_in(flt[1]), .input_volt_fault_in(flt[2]),
    .fan_fault_in(flt[3]), .other_shutdown_fault_in(flt[4]),
    .main_output_en_out(men), .standby_output_en_out(sen),
    .power_good_out(pg), .alert_out_n(al_n), .led_out(led),
    .fan_rpm_out(rpm), .nvm_we_out(nwe), .nvm_addr_out(nadr),
    .nvm_data_out(nd), .fw_strobe_out(fws), .fw_word_out(fww));
  always @(posedge clk) begin
    cyc_n++;
    if (nwe === 1'b1) begin
      n_rec++;
      rec = nd;
      slot = nadr;
    end
    if (fws === 1'b1) begin
      n_fw++;
      fw = fww;
    end
    if (cyc_n == 90000) begin
      failures++;
      end_of_test();
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    host_u.xfer(1'b0, a, 32'h0, q);
  endtask
  task set_t(input int i, input logic [TEMP_W-1:0] v);
    tmp[i] <= v;
    repeat (4) @(posedge clk);
  endtask
  task st_chk(input string s, input logic [7:0] e);
    rd(REG_STATUS);
    chk(s, {24'h0, e}, {24'h0, q[7:0]});
  endtask
  task do_reset(input logic r);
    rstn <= 1'b0;
    rev <= r;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask
  task t_start;
    chk("reset outs", {12'h0, FAN_MIN_RPM, 4'h5},
      {12'h0, rpm, men, sen, pg, al_n});
    tmp <= '{8'h21, 8'h22, 8'h23};
    repeat (3) @(posedge clk);
    rd(REG_TEMP_INLET);
    chk("inlet", 32'h21, {24'h0, q[7:0]});
    rd(REG_TEMP_RECT1);
    chk("rect1", 32'h22, {24'h0, q[7:0]});
    rd(REG_TEMP_RECT2);
    chk("rect2", 32'h23, {24'h0, q[7:0]});
    rd(12'hffc);
    chk("unmapped", 32'h0, q);
    wr(REG_CTRL, 32'h1);
  endtask
  function automatic logic inband(input int t);
    return rpm >= t - t / 10 && rpm <= t + t / 10;
  endfunction
  task t_fan(input int p, input int c);
    int t;
    int n;
    t = 6000 + 4 * p + 200 * (c > 25 ? c - 25 : 0);
    pwr <= PWR_W'(p);
    tmp[0] <= TEMP_W'(c);
    n = 0;
    while (inband(t) !== 1'b1 && n < 6000 * TICK) begin
      @(posedge clk);
      n++;
    end
    chk("fan settle", 32'h1, {31'h0, n < 6000 * TICK});
    repeat (40 * TICK) @(posedge clk);
    chk("fan band", 32'h1, {31'h0, inband(t)});
  endtask
  task t_sense(input logic r);
    logic [TEMP_W-1:0] w;
    logic [TEMP_W-1:0] s;
    int m;
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      w = i == 0 ? (r ? INLET_WARN_REV : INLET_WARN_NORM)
        : (r ? RECT_WARN_REV : RECT_WARN_NORM);
      s = i == 0 ? (r ? INLET_SHUT_REV : INLET_SHUT_NORM)
        : (r ? RECT_SHUT_REV : RECT_SHUT_NORM);
      set_t(i, w - 8'h01);
      st_chk("below warn", 8'h00);
      set_t(i, w);
      st_chk("at warn", 8'h01 << i);
      chk("fan max", {16'h0, FAN_MAX_RPM}, {16'h0, rpm});
      chk("warn out", {30'h0, LED_WARN}, {29'h0, al_n, led});
      rd(REG_FAN);
      chk("fan reg", {16'h0, FAN_MAX_RPM}, q);
      set_t(i, s);
      st_chk("at shut", 8'h01 << i);
      m = n_rec;
      set_t(i, s + 8'h01);
      st_chk("past shut", 8'h40 | 8'h09 << i);
      chk("shut out", {30'h0, LED_FAULT}, {29'h0, men | pg, led});
      chk("rec shut", 32'h1, {31'h0, n_rec == m + 1 && rec[29]});
      set_t(i, 8'h19);
      wr(REG_STATUS, 32'h1ff);
      chk("main back", 32'h1, {31'h0, men & pg});
    end
  endtask
  task t_aux;
    aux <= 1'b1;
    set_t(1, RECT_SHUT_NORM + 8'h01);
    chk("aux trip", 32'h2, {30'h0, men, sen});
    set_t(1, 8'h19);
    aux <= 1'b0;
    wr(REG_STATUS, 32'h1ff);
  endtask
  task t_faults;
    int m;
    for (int k = 0; k < 5; k++) begin
      m = n_rec;
      flt[k] <= 1'b1;
      repeat (4) @(posedge clk);
      flt[k] <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rec", 32'h1, {31'h0, n_rec == m + 1 && rec[24 + k]});
    end
    wr(REG_STATUS, 32'h1ff);
    wr(REG_CTRL, 32'h0);
    wr(REG_REC_SEL, {29'h0, slot});
    rd(REG_REC_SEL);
    chk("rec sel", 32'h0000_0800, q);
    rd(REG_REC_DATA);
    chk("rec read", rec, q);
  endtask
  task t_fw;
    int m;
    m = n_fw;
    wr(REG_CTRL, 32'h1);
    wr(REG_FW_DATA, 32'h1357_9bdf);
    repeat (2) @(posedge clk);
    rd(REG_STATUS);
    chk("fw refused", 32'h1, {31'h0, n_fw == m && q[ST_FW_REFUSED]});
    wr(REG_STATUS, 32'h100);
    wr(REG_CTRL, 32'h0);
    wr(REG_FW_DATA, 32'h5a5a_c3c3);
    repeat (2) @(posedge clk);
    chk("fw word", 32'h5a5a_c3c3, fw);
    chk("fw count", 32'h1, {31'h0, n_fw == m + 1});
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_start;
    t_fan(500, 30);
    t_fan(1000, 30);
    t_fan(0, 20);
    t_sense(1'b0);
    t_aux;
    t_faults;
    t_fw;
    do_reset(1'b1);
    t_sense(1'b1);
    end_of_test();
  end
endmodule // tb_top
bind tfm_monitor tfm_monitor_sva sva_u (.clk_in, .rstn_in, .wb_cyc_in,
  .wb_stb_in, .wb_ack_out, .reverse_airflow_variant_in, .aux_affected_in,
  .temp_inlet_in, .overvoltage_fault_in, .main_output_en_out,
  .power_good_out, .alert_out_n, .led_out, .fan_rpm_out, .nvm_we_out,
  .fw_strobe_out);
`default_nettype wire

/* File: tfm_host.sv */
// Purpose: Management host issuing classic Wishbone cycles
// Assumes: One request at a time on all byte lanes
// Notes: Waits for ack as long as it takes; the bench timeout ends a hang
`default_nettype none
module tfm_host
  import tfm_pkg::*;
(
  input wire logic clk_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [ADDR_W-1:0] adr_out,
  output logic [31:0] dat_out,
  input wire logic ack_in,
  input wire logic [31:0] dat_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 12'h000;
    dat_out = 32'h0;
  end
  task xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    // Request held until ack is sampled high
    do begin
      @(posedge clk_in);
    end while (ack_in !== 1'b1);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a;
    dat_out <= ~d;
  endtask
endmodule // tfm_host
`default_nettype wire

/* File: tfm_monitor.sv */
// Purpose: Thermal, fan and fault supervisor with event recorder
// Assumes: Classic Wishbone slave, all inputs synchronous to clk_in
// Notes: One-cycle bus answer; recorder writes mirror to an NVM port
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`default_nettype none
module tfm_monitor
  import tfm_pkg::*;
#(
  parameter int FAN_TICK_CYC = FAN_TICK_CYC_DEF,
  parameter int REC_AW = 3
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic reverse_airflow_variant_in,
  input wire logic [TEMP_W-1:0] temp_inlet_in,
  input wire logic [TEMP_W-1:0] temp_rect1_in,
  input wire logic [TEMP_W-1:0] temp_rect2_in,
  input wire logic [PWR_W-1:0] output_power_in,
  input wire logic aux_affected_in,
  input wire logic overvoltage_fault_in,
  input wire logic overcurrent_fault_in,
  input wire logic input_volt_fault_in,
  input wire logic fan_fault_in,
  input wire logic other_shutdown_fault_in,
  output logic main_output_en_out,
  output logic standby_output_en_out,
  output logic power_good_out,
  output logic alert_out_n,
  output logic [1:0] led_out,
  output logic [RPM_W-1:0] fan_rpm_out,
  output logic nvm_we_out,
  output logic [REC_AW-1:0] nvm_addr_out,
  output logic [31:0] nvm_data_out,
  output logic fw_strobe_out,
  output logic [31:0] fw_word_out
);
  localparam int REC_DEPTH = 1 << REC_AW;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic strap_done;
    logic reverse;
    logic run;
    logic [2:0] warn_st;
    logic [2:0] shut_st;
    logic [2:0] shut_q;
    logic main_trip;
    logic stby_trip;
    logic fw_refused;
    logic [NFAULT-1:0] fault_q;
    logic [RPM_W-1:0] rpm;
    logic moving;
    logic [31:0] tick;
    logic [REC_AW-1:0] rec_wr;
    logic [REC_AW:0] rec_cnt;
    logic [REC_AW-1:0] rec_sel;
    logic [REC_DEPTH-1:0][31:0] rec_mem;
    logic nvm_we;
    logic [REC_AW-1:0] nvm_addr;
    logic [31:0] nvm_data;
    logic fw_stb;
    logic [31:0] fw_word;
  } tfm_state_t;

  tfm_state_t s;
  tfm_state_t next_s;

  logic [2:0] warn_live;
  logic [2:0] shut_live;
  logic [TEMP_W-1:0] inlet_warn_lim;
  logic [TEMP_W-1:0] inlet_shut_lim;
  logic [TEMP_W-1:0] rect_warn_lim;
  logic [TEMP_W-1:0] rect_shut_lim;
  logic [TEMP_W-1:0] temp_vec [3];
  logic [TEMP_W-1:0] warn_vec [3];
  logic [TEMP_W-1:0] shut_vec [3];

  always_comb begin
    inlet_warn_lim = s.reverse ? INLET_WARN_REV : INLET_WARN_NORM;
    inlet_shut_lim = s.reverse ? INLET_SHUT_REV : INLET_SHUT_NORM;
    rect_warn_lim = s.reverse ? RECT_WARN_REV : RECT_WARN_NORM;
    rect_shut_lim = s.reverse ? RECT_SHUT_REV : RECT_SHUT_NORM;
    temp_vec[0] = temp_inlet_in;
    temp_vec[1] = temp_rect1_in;
    temp_vec[2] = temp_rect2_in;
    warn_vec[0] = inlet_warn_lim;
    warn_vec[1] = rect_warn_lim;
    warn_vec[2] = rect_warn_lim;
    shut_vec[0] = inlet_shut_lim;
    shut_vec[1] = rect_shut_lim;
    shut_vec[2] = rect_shut_lim;
  end

  for (genvar i = 0; i < 3; i++) begin : g_sensor
    tfm_sensor_cmp u_cmp (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .temp_in(temp_vec[i]),
      .warn_lim_in(warn_vec[i]),
      .shut_lim_in(shut_vec[i]),
      .warn_out(warn_live[i]),
      .shut_out(shut_live[i])
    );
  end

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [NFAULT-1:0] faults;
  logic fault_edge;
  logic shut_edge;
  logic event_hit;
  logic main_en;
  logic stby_en;
  logic fan_max;
  logic [TEMP_W-1:0] excess;
  logic [TEMP_W-1:0] rect_max;
  logic [19:0] law;
  logic [RPM_W-1:0] target;
  logic [RPM_W-1:0] diff;
  logic [31:0] rec_word;
  logic [31:0] status_word;
  logic [31:0] rd;

  always_comb begin
    next_s = s;
    req = wb_cyc_in && wb_stb_in && !s.ack;
    wr = req && wb_we_in;
    wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
             {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wbits = wb_dat_in & wmask;
    faults = {other_shutdown_fault_in, fan_fault_in, input_volt_fault_in,
              overcurrent_fault_in, overvoltage_fault_in};
    main_en = s.run && !s.main_trip;
    stby_en = !s.stby_trip;
    fan_max = |warn_live;

    // Airflow strap caught once after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.reverse = reverse_airflow_variant_in;
    end

    // Shutdown trips main or standby output
    if (|shut_live) begin
      if (aux_affected_in) begin
        next_s.stby_trip = 1'b1;
      end else begin
        next_s.main_trip = 1'b1;
      end
    end
    // Other faults shut the main output
    if (|faults) begin
      next_s.main_trip = 1'b1;
    end

    fault_edge = |(faults & ~s.fault_q);
    shut_edge = |(shut_live & ~s.shut_q);
    event_hit = fault_edge || shut_edge;
    next_s.fault_q = faults;
    next_s.shut_q = shut_live;

    rect_max = (temp_rect1_in > temp_rect2_in) ? temp_rect1_in
                                                : temp_rect2_in;
    rec_word = {2'h0, shut_edge, faults & ~s.fault_q, temp_inlet_in,
                rect_max, output_power_in[PWR_W-1:4]};
    // Snapshot stored and sent to NVM
    next_s.nvm_we = event_hit;
    if (event_hit) begin
      next_s.rec_mem[s.rec_wr] = rec_word;
      next_s.nvm_addr = s.rec_wr;
      next_s.nvm_data = rec_word;
      next_s.rec_wr = s.rec_wr + 1'b1;
      if (s.rec_cnt != (REC_AW + 1)'(REC_DEPTH)) begin
        next_s.rec_cnt = s.rec_cnt + 1'b1;
      end
    end

    // Fan law from power and inlet temperature
    excess = (temp_inlet_in > FAN_IDLE_C) ? temp_inlet_in - FAN_IDLE_C
                                          : '0;
    law = 20'(FAN_MIN_RPM) + 20'(output_power_in) * FAN_PWR_GAIN
          + 20'(excess) * FAN_TEMP_GAIN;
    target = (law > 20'(FAN_MAX_RPM)) ? FAN_MAX_RPM : law[RPM_W-1:0];
    if (target < FAN_MIN_RPM) begin
      target = FAN_MIN_RPM;
    end
    diff = (target > s.rpm) ? target - s.rpm : s.rpm - target;

    next_s.tick = s.tick + 32'h1;
    if (fan_max) begin
      next_s.rpm = FAN_MAX_RPM;
      next_s.moving = 1'b0;
    end else if (s.tick >= 32'(FAN_TICK_CYC - 1)) begin
      next_s.tick = '0;
      // Dead band of one sixteenth of speed
      if (s.moving || diff > (s.rpm >> 4)) begin
        next_s.moving = 1'b1;
        // Step sized to settle within 60 s
        if (diff <= FAN_STEP) begin
          next_s.rpm = target;
          next_s.moving = 1'b0;
        end else if (target > s.rpm) begin
          next_s.rpm = s.rpm + FAN_STEP;
        end else begin
          next_s.rpm = s.rpm - FAN_STEP;
        end
      end
    end
    if (s.rpm < FAN_MIN_RPM) begin
      next_s.rpm = FAN_MIN_RPM;
    end

    // Sticky status: write one clears, a new event wins
    if (wr && wb_adr_in == REG_STATUS) begin
      next_s.warn_st = s.warn_st & ~wbits[ST_WARN+:3];
      next_s.shut_st = s.shut_st & ~wbits[ST_SHUT+:3];
      next_s.fw_refused = s.fw_refused & ~wbits[ST_FW_REFUSED];
      if (wbits[ST_MAIN_TRIP] && !(|faults) &&
          !((|shut_live) && !aux_affected_in)) begin
        next_s.main_trip = 1'b0;
      end
      if (wbits[ST_STBY_TRIP] && !((|shut_live) && aux_affected_in)) begin
        next_s.stby_trip = 1'b0;
      end
    end
    next_s.warn_st = next_s.warn_st | warn_live;
    next_s.shut_st = next_s.shut_st | shut_live;

    if (wr && wb_adr_in == REG_CTRL && wb_sel_in[0]) begin
      next_s.run = wb_dat_in[CTRL_RUN];
    end
    if (wr && wb_adr_in == REG_REC_SEL && wb_sel_in[0]) begin
      next_s.rec_sel = wb_dat_in[REC_AW-1:0];
    end
    next_s.fw_stb = 1'b0;
    if (wr && wb_adr_in == REG_FW_DATA) begin
      if (!main_en && stby_en) begin
        next_s.fw_stb = 1'b1;
        next_s.fw_word = wb_dat_in;
      end else begin
        next_s.fw_refused = 1'b1;
      end
    end

    status_word = '0;
    status_word[ST_WARN+:3] = s.warn_st;
    status_word[ST_SHUT+:3] = s.shut_st;
    status_word[ST_MAIN_TRIP] = s.main_trip;
    status_word[ST_STBY_TRIP] = s.stby_trip;
    status_word[ST_FW_REFUSED] = s.fw_refused;
    status_word[ST_MAIN_EN] = main_en;
    status_word[ST_STBY_EN] = stby_en;
    status_word[ST_FAN_MAX] = fan_max;
    status_word[ST_REVERSE] = s.reverse;

    // Recorder reads need no main output
    unique case (wb_adr_in)
      REG_CTRL: rd = {31'h0, s.run};
      REG_STATUS: rd = status_word;
      REG_FAN: rd = {16'h0, s.rpm};
      REG_REC_SEL: rd = {16'h0, 8'(s.rec_cnt), 8'(s.rec_sel)};
      REG_REC_DATA: rd = s.rec_mem[s.rec_sel];
      REG_TEMP_INLET: rd = {24'h0, temp_inlet_in};
      REG_TEMP_RECT1: rd = {24'h0, temp_rect1_in};
      REG_TEMP_RECT2: rd = {24'h0, temp_rect2_in};
      default: rd = '0;
    endcase
    next_s.ack = req;
    if (req && !wb_we_in) begin
      next_s.rdata = rd;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
      s.run <= CTRL_RUN_RST;
      s.rpm <= FAN_MIN_RPM;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_out = s.ack;
  assign wb_dat_out = s.rdata;
  assign main_output_en_out = s.run && !s.main_trip;
  assign standby_output_en_out = !s.stby_trip;
  // LED, power good and alert driven together
  assign power_good_out = s.run && !s.main_trip && !(|s.shut_st);
  assign alert_out_n = !((|s.warn_st) || (|s.shut_st) ||
                         s.main_trip || s.stby_trip);
  assign led_out = (s.main_trip || s.stby_trip || (|s.shut_st))
                   ? LED_FAULT : ((|s.warn_st) ? LED_WARN : LED_OK);
  assign fan_rpm_out = s.rpm;
  assign nvm_we_out = s.nvm_we;
  assign nvm_addr_out = s.nvm_addr;
  assign nvm_data_out = s.nvm_data;
  assign fw_strobe_out = s.fw_stb;
  assign fw_word_out = s.fw_word;
endmodule // tfm_monitor
`default_nettype wire

/* File: tfm_monitor_sva.sv */
// Purpose: Port-level timing checks on the monitor
// Assumes: Airflow strap steady while out of reset
// Notes: Bound to the monitor from the bench top
`default_nettype none
module tfm_monitor_sva
  import tfm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic reverse_airflow_variant_in,
  input wire logic aux_affected_in,
  input wire logic [TEMP_W-1:0] temp_inlet_in,
  input wire logic overvoltage_fault_in,
  input wire logic main_output_en_out,
  input wire logic power_good_out,
  input wire logic alert_out_n,
  input wire logic [1:0] led_out,
  input wire logic [RPM_W-1:0] fan_rpm_out,
  input wire logic nvm_we_out,
  input wire logic fw_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic warn;
  logic shut;
  assign warn = temp_inlet_in >=
    (reverse_airflow_variant_in ? INLET_WARN_REV : INLET_WARN_NORM);
  assign shut = !aux_affected_in && temp_inlet_in >
    (reverse_airflow_variant_in ? INLET_SHUT_REV : INLET_SHUT_NORM);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_bus_answer: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("Bus request unanswered");
  a_fan_floor: assert property (
    fan_rpm_out >= FAN_MIN_RPM) else $error("Fan below minimum");
  a_warn_fan: assert property (
    warn [*3] |-> fan_rpm_out == FAN_MAX_RPM) else $error("Fan not max");
  a_shut_main: assert property (
    shut [*4] |-> !main_output_en_out) else $error("Main left on");
  a_warn_flag: assert property (
    warn [*3] |-> !alert_out_n && led_out != LED_OK)
    else $error("Warning not shown");
  a_pg_main: assert property (
    power_good_out |-> main_output_en_out) else $error("Good without main");
  a_shut_pg: assert property (
    shut [*4] |-> !power_good_out) else $error("Power good kept on shutdown");
  a_rec_write: assert property (
    $rose(overvoltage_fault_in) |-> ##[1:3] nvm_we_out)
    else $error("No record write");
  a_fw_gate: assert property (
    fw_strobe_out |-> !main_output_en_out && !$past(main_output_en_out))
    else $error("Firmware taken while running");
  c_rec: cover property (nvm_we_out);
  c_fw: cover property (fw_strobe_out);
  c_max: cover property (fan_rpm_out == FAN_MAX_RPM);
endmodule // tfm_monitor_sva
`default_nettype wire

/* File: tfm_pkg.sv */
// Purpose: Shared constants for the thermal, fan and fault monitor
// Assumes: 125 MHz clock, temperatures in whole degrees C, power in W
// Notes: Register offsets are byte addresses on a 32-bit bus
`default_nettype none
package tfm_pkg;
  localparam int TEMP_W = 8;
  localparam int PWR_W = 12;
  localparam int RPM_W = 16;
  localparam int ADDR_W = 12;
  localparam int NFAULT = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_FAN = 12'h008;
  localparam logic [ADDR_W-1:0] REG_REC_SEL = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_REC_DATA = 12'h010;
  localparam logic [ADDR_W-1:0] REG_FW_DATA = 12'h014;
  // Temperature readouts sit at four times their command code
  localparam logic [7:0] CMD_TEMP_INLET = 8'h8d;
  localparam logic [7:0] CMD_TEMP_RECT1 = 8'h8e;
  localparam logic [7:0] CMD_TEMP_RECT2 = 8'hea;
  localparam logic [ADDR_W-1:0] REG_TEMP_INLET = {2'h0, CMD_TEMP_INLET, 2'h0};
  localparam logic [ADDR_W-1:0] REG_TEMP_RECT1 = {2'h0, CMD_TEMP_RECT1, 2'h0};
  localparam logic [ADDR_W-1:0] REG_TEMP_RECT2 = {2'h0, CMD_TEMP_RECT2, 2'h0};

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int ST_WARN = 0;
  localparam int ST_SHUT = 3;
  localparam int ST_MAIN_TRIP = 6;
  localparam int ST_STBY_TRIP = 7;
  localparam int ST_FW_REFUSED = 8;
  localparam int ST_MAIN_EN = 16;
  localparam int ST_STBY_EN = 17;
  localparam int ST_FAN_MAX = 18;
  localparam int ST_REVERSE = 19;
  localparam logic CTRL_RUN_RST = 1'b0;

  // Thresholds in degrees C (normal / reverse airflow)
  localparam logic [TEMP_W-1:0] INLET_WARN_NORM = 8'h3c;
  localparam logic [TEMP_W-1:0] INLET_WARN_REV = 8'h41;
  localparam logic [TEMP_W-1:0] INLET_SHUT_NORM = 8'h41;
  localparam logic [TEMP_W-1:0] INLET_SHUT_REV = 8'h46;
  localparam logic [TEMP_W-1:0] RECT_WARN_NORM = 8'h73;
  localparam logic [TEMP_W-1:0] RECT_WARN_REV = 8'h6a;
  localparam logic [TEMP_W-1:0] RECT_SHUT_NORM = 8'h78;
  localparam logic [TEMP_W-1:0] RECT_SHUT_REV = 8'h70;

  // Fan law
  localparam logic [RPM_W-1:0] FAN_MIN_RPM = 16'h1770;
  localparam logic [RPM_W-1:0] FAN_MAX_RPM = 16'h4e20;
  localparam logic [TEMP_W-1:0] FAN_IDLE_C = 8'h19;
  localparam logic [19:0] FAN_PWR_GAIN = 20'h00004;
  localparam logic [19:0] FAN_TEMP_GAIN = 20'h000c8;

  // Timing
  localparam int CLK_HZ = 32'h0773_5940;
  localparam int FAN_TICK_US = 32'h0000_2710;
  localparam int FAN_SETTLE_S = 32'h0000_003c;
  localparam int FAN_SETTLE_US = FAN_SETTLE_S * 32'h000f_4240;
  localparam int FAN_TICK_CYC_DEF = FAN_TICK_US * (CLK_HZ / 32'h000f_4240);
  localparam int FAN_SPAN = int'(FAN_MAX_RPM) - int'(FAN_MIN_RPM);
  localparam int FAN_STEP_I =
    (FAN_SPAN * FAN_TICK_US + FAN_SETTLE_US - 1) / FAN_SETTLE_US;
  localparam logic [RPM_W-1:0] FAN_STEP = RPM_W'(FAN_STEP_I);

  typedef enum logic [1:0] {LED_OK, LED_WARN, LED_FAULT} tfm_led_t;
endpackage
`default_nettype wire

/* File: tfm_sensor_cmp.sv */
// Purpose: Compares one temperature against its warning and shutdown limits
// Assumes: Unsigned temperatures and limits in whole degrees C
// Notes: Warning when the limit is reached, shutdown once it is exceeded
`default_nettype none
module tfm_sensor_cmp
  import tfm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [TEMP_W-1:0] temp_in,
  input wire logic [TEMP_W-1:0] warn_lim_in,
  input wire logic [TEMP_W-1:0] shut_lim_in,
  output logic warn_out,
  output logic shut_out
);
  typedef struct packed {
    logic warn;
    logic shut;
  } tfm_cmp_t;

  tfm_cmp_t s;
  tfm_cmp_t next_s;

  always_comb begin
    next_s = s;
    next_s.warn = (temp_in >= warn_lim_in);
    next_s.shut = (temp_in > shut_lim_in);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign warn_out = s.warn;
  assign shut_out = s.shut;
endmodule // tfm_sensor_cmp
`default_nettype wire
